//--- verilog/wit_pkg.sv
// constants, register map and field layout of the watchdog/interval timer
// assumes one 250 MHz system clock; all timing is counted in its cycles
package wit_pkg;
   // system clock figures
   localparam int CLK_MHZ = 250;
   // internal chip reset and external trip pulse, in system clock states
   localparam int WD_RESET_STATES = 518;
   localparam int TRIP_OUT_STATES = 132;
   localparam int STATES_PER_CYCLE = 1;
   localparam logic [9:0] WD_RESET_CYCLES = 10'(WD_RESET_STATES * STATES_PER_CYCLE);
   localparam logic [9:0] TRIP_OUT_CYCLES = 10'(TRIP_OUT_STATES * STATES_PER_CYCLE);

   // register port addresses (byte addresses within the block)
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_COUNT = 4'h1;
   localparam logic [3:0] ADDR_TRIP = 4'h3;
   localparam logic [3:0] ADDR_IRQ_STAT = 4'h4;
   localparam logic [3:0] ADDR_IRQ_EN = 4'h5;
   localparam logic [3:0] ADDR_IRQ_CLR = 4'h6;

   // password bytes in the upper half of a word write
   localparam logic [7:0] PW_COUNT = 8'h5A;
   localparam logic [7:0] PW_CTRL = 8'hA5;
   localparam logic [7:0] PW_TRIP_OE = 8'h5A;
   localparam logic [7:0] PW_TRIP_CLR = 8'hA5;
   localparam logic [7:0] TRIP_CLR_DATA = 8'h00;

   // control/status byte fields
   localparam int CTRL_OVF_BIT = 7;
   localparam int CTRL_MODE_BIT = 6;
   localparam int CTRL_EN_BIT = 5;
   localparam int CTRL_CKS_LSB = 0;
   localparam logic [1:0] CTRL_RSVD = 2'h3;
   // trip status byte fields
   localparam int TRIP_FLAG_BIT = 7;
   localparam int TRIP_OE_BIT = 6;
   localparam logic [5:0] TRIP_RSVD = 6'h3F;

   // interrupt status layout
   localparam int IRQ_OVF_BIT = 0;
   localparam int IRQ_TRIP_BIT = 1;
   localparam int IRQ_W = 2;

   // reset values and the counter maximum
   localparam logic [7:0] COUNT_RESET = 8'h00;
   localparam logic [7:0] COUNT_MAX = 8'hFF;
   localparam logic [2:0] CKS_RESET = 3'h0;

   // prescaler: log2 of each divide ratio, codes zero to seven
   localparam int PRE_W = 12;
   localparam logic [3:0] DIV_LOG2 [8] = '{4'h1, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'hB, 4'hC};
endpackage : wit_pkg

//--- verilog/wit_prescaler.sv
// prescaler: one-cycle count pulse at the selected division of the system clock
// assumes a synchronous clear from the owner and a stable select while counting
`timescale 1ns/1ps
module wit_prescaler
   import wit_pkg::*;
#(
   parameter int WIDTH = PRE_W
) (
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic clear_in,
   input wire logic [2:0] sel_in,
   output logic tick_out
);
   logic [WIDTH-1:0] cnt;
   logic [WIDTH-1:0] mask;

   generate
      if (WIDTH < PRE_W) begin : g_bad
         $error("prescaler narrower than the largest divide ratio");
      end
   endgenerate

   // ratio is a power of two: pulse when the low log2 bits are all ones
   always_comb begin
      mask = WIDTH'((1 << DIV_LOG2[sel_in]) - 1);
   end

   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cnt <= '0;
         tick_out <= 1'b0;
      end else if (clear_in) begin
         cnt <= '0;
         tick_out <= 1'b0;
      end else begin
         cnt <= cnt + WIDTH'(1);
         tick_out <= ((cnt & mask) == mask);
      end
   end
endmodule : wit_prescaler

//--- verilog/wit_timer.sv
// watchdog / interval timer top: counter, control, trip reset and interrupts
// assumes a single-cycle strobe register port; rst_n_in is the hard init pin
//
// Contract
// - watchdog overflow holds the internal chip reset for 518 states.
// - with trip output enabled, the trip pin goes low for 132 states.
// - watchdog reset shares the pin reset vector; trip flag tells them apart.
// - a pin reset in the same cycle as a watchdog reset wins.
// - interval mode raises an interrupt request on every overflow, unless a same-cycle control write clears enable or sets watchdog mode.
// - wrap from maximum to zero sets the overflow flag and its effect together.
// - trip flag is set on watchdog overflow together with the chip reset.
// - internal reset clears overflow flag, keeps trip flag; software clears it.
// - interval interrupt is requested whenever the overflow flag sets in interval mode, unless a same-cycle control write clears enable or sets watchdog mode.
// - a count pulse during a count write is lost; the written value stays.
// - count and control take only passworded word writes; byte writes do nothing.
// - with enable clear the count is held at zero, except for one cycle after a count write; setting it starts counting.
// - divider select picks system clock over 2,32,64,128,256,512,2048,4096.
// - software clears the overflow flag only by reading it set, then writing zero.
`timescale 1ns/1ps
module wit_timer
   import wit_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic wr_in,
   input wire logic wr_word_in,
   input wire logic rd_in,
   output logic [7:0] rdata_out,
   output logic chip_reset_n_out,
   output logic trip_out_pin_n_out,
   output logic interval_irq_out,
   output logic irq_out
);
   typedef struct packed {
      logic [7:0] count;
      logic ovf;
      logic mode;
      logic en;
      logic [2:0] cks;
      logic trip;
      logic trip_oe;
      logic ovf_armed;
      logic trip_armed;
      logic [9:0] rst_cnt;
      logic [9:0] pin_cnt;
      logic [IRQ_W-1:0] istat;
      logic [IRQ_W-1:0] ien;
      logic [7:0] rdata;
      logic chip_rst_n;
      logic trip_n;
      logic interval_irq;
      logic irq;
   } wit_state_s;

   wit_state_s st;
   wit_state_s next_st;
   logic [1:0] rst_sync;
   logic rst_n;
   logic tick;
   logic in_reset;
   logic wr_cnt;
   logic wr_ctrl;
   logic wr_trip_oe;
   logic wr_trip_clr;
   logic overflow;
   logic wd_over;
   logic [IRQ_W-1:0] ev;

   // pin reset released through two flops; assertion stays asynchronous
   always_ff @(posedge mclk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end
   assign rst_n = rst_sync[1];

   assign in_reset = (st.rst_cnt != 10'h000);

   // divider held cleared while stopped so the first period after enable is whole
   wit_prescaler #(
      .WIDTH(PRE_W)
   ) u_pre (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n),
      .clear_in(!st.en || in_reset),
      .sel_in(st.cks),
      .tick_out(tick)
   );

   // byte writes never reach the counter or control registers
   assign wr_cnt = wr_in && wr_word_in && !in_reset && (addr_in == ADDR_CTRL)
                   && (wdata_in[15:8] == PW_COUNT);
   assign wr_ctrl = wr_in && wr_word_in && !in_reset && (addr_in == ADDR_CTRL)
                    && (wdata_in[15:8] == PW_CTRL);
   assign wr_trip_oe = wr_in && wr_word_in && !in_reset && (addr_in == ADDR_TRIP)
                       && (wdata_in[15:8] == PW_TRIP_OE);
   assign wr_trip_clr = wr_in && wr_word_in && !in_reset && (addr_in == ADDR_TRIP)
                        && (wdata_in[15:8] == PW_TRIP_CLR)
                        && (wdata_in[7:0] == TRIP_CLR_DATA);

   // a pulse in a count-write cycle is dropped in favour of the write
   assign overflow = tick && st.en && !in_reset && !wr_cnt && (st.count == COUNT_MAX);
   assign wd_over = overflow && st.mode;
   assign ev[IRQ_OVF_BIT] = overflow;
   assign ev[IRQ_TRIP_BIT] = wd_over;

   always_comb begin
      next_st = st;
      // counting
      if (wr_cnt) begin
         next_st.count = wdata_in[7:0];
      end else if (!st.en) begin
         next_st.count = COUNT_RESET;
      end else if (tick) begin
         next_st.count = st.count + 8'h01;
      end
      // overflow flag: clear needs an armed read; a new overflow beats the clear
      if (wr_ctrl) begin
         next_st.mode = wdata_in[CTRL_MODE_BIT];
         next_st.en = wdata_in[CTRL_EN_BIT];
         next_st.cks = wdata_in[CTRL_CKS_LSB +: 3];
         if (!wdata_in[CTRL_OVF_BIT] && st.ovf_armed) begin
            next_st.ovf = 1'b0;
         end
         next_st.ovf_armed = 1'b0;
      end
      if (rd_in && (addr_in == ADDR_CTRL) && st.ovf) begin
         next_st.ovf_armed = 1'b1;
      end
      if (overflow) begin
         next_st.ovf = 1'b1;
      end
      // trip status
      if (wr_trip_oe) begin
         next_st.trip_oe = wdata_in[TRIP_OE_BIT];
      end
      if (wr_trip_clr) begin
         if (st.trip_armed) begin
            next_st.trip = 1'b0;
         end
         next_st.trip_armed = 1'b0;
      end
      if (rd_in && (addr_in == ADDR_TRIP) && st.trip) begin
         next_st.trip_armed = 1'b1;
      end
      if (wd_over) begin
         next_st.trip = 1'b1;
         next_st.rst_cnt = WD_RESET_CYCLES;
         if (st.trip_oe) begin
            next_st.pin_cnt = TRIP_OUT_CYCLES;
         end
      end
      // internal chip reset: clears the counter side, keeps trip flag and its enable
      if (in_reset) begin
         next_st.rst_cnt = st.rst_cnt - 10'h001;
         next_st.count = COUNT_RESET;
         next_st.ovf = 1'b0;
         next_st.mode = 1'b0;
         next_st.en = 1'b0;
         next_st.cks = CKS_RESET;
         next_st.ovf_armed = 1'b0;
         next_st.istat = '0;
         next_st.ien = '0;
      end
      if (st.pin_cnt != 10'h000) begin
         next_st.pin_cnt = st.pin_cnt - 10'h001;
      end
      // interrupt status: set wins over a same-cycle clear
      if (wr_in && !in_reset && (addr_in == ADDR_IRQ_CLR)) begin
         next_st.istat = next_st.istat & ~wdata_in[IRQ_W-1:0];
      end
      if (wr_in && !in_reset && (addr_in == ADDR_IRQ_EN)) begin
         next_st.ien = wdata_in[IRQ_W-1:0];
      end
      if (!in_reset) begin
         next_st.istat = next_st.istat | ev;
      end
      // read data, one cycle after the strobe
      next_st.rdata = 8'h00;
      if (rd_in) begin
         case (addr_in)
            ADDR_CTRL: next_st.rdata = {st.ovf, st.mode, st.en, CTRL_RSVD, st.cks};
            ADDR_COUNT: next_st.rdata = st.count;
            ADDR_TRIP: next_st.rdata = {st.trip, st.trip_oe, TRIP_RSVD};
            ADDR_IRQ_STAT: next_st.rdata = 8'(st.istat);
            ADDR_IRQ_EN: next_st.rdata = 8'(st.ien);
            default: next_st.rdata = 8'h00;
         endcase
      end
      // registered outputs
      next_st.chip_rst_n = !((next_st.rst_cnt != 10'h000));
      next_st.trip_n = (next_st.pin_cnt == 10'h000);
      next_st.interval_irq = next_st.ovf && !next_st.mode && next_st.en;
      next_st.irq = |(next_st.istat & next_st.ien);
   end

   // pin reset clears everything, trip flag included, and overrides a same-cycle trip
   always_ff @(posedge mclk_in or negedge rst_n) begin
      if (!rst_n) begin
         st <= '0;
         st.chip_rst_n <= 1'b1;
         st.trip_n <= 1'b1;
      end else begin
         st <= next_st;
      end
   end

   assign rdata_out = st.rdata;
   assign chip_reset_n_out = st.chip_rst_n;
   assign trip_out_pin_n_out = st.trip_n;
   assign interval_irq_out = st.interval_irq;
   assign irq_out = st.irq;

   // delay bounds must be local plain ints, so they are derived here from the package counts
   localparam int WD_LEN_M1 = WD_RESET_STATES - 1;
   localparam int TRIP_LEN_M1 = TRIP_OUT_STATES - 1;

   property p_wd_reset_len;
      @(posedge mclk_in) disable iff (!rst_n)
      $fell(chip_reset_n_out) |-> ##[WD_LEN_M1:WD_LEN_M1] !chip_reset_n_out ##1 chip_reset_n_out;
   endproperty
   a_wd_reset_len: assert property (p_wd_reset_len) else $error("chip reset length wrong");

   property p_trip_len;
      @(posedge mclk_in) disable iff (!rst_n)
      $fell(trip_out_pin_n_out) |-> ##[TRIP_LEN_M1:TRIP_LEN_M1] !trip_out_pin_n_out
         ##1 trip_out_pin_n_out;
   endproperty
   a_trip_len: assert property (p_trip_len) else $error("trip pulse length wrong");

   property p_trip_gated;
      @(posedge mclk_in) disable iff (!rst_n)
      (wd_over && !st.trip_oe) |=> trip_out_pin_n_out;
   endproperty
   a_trip_gated: assert property (p_trip_gated) else $error("trip pulse while disabled");

   property p_wd_sets_trip;
      @(posedge mclk_in) disable iff (!rst_n)
      wd_over |=> st.trip && st.ovf && !chip_reset_n_out ##1 !st.ovf && st.trip;
   endproperty
   a_wd_sets_trip: assert property (p_wd_sets_trip) else $error("trip flag or ovf wrong");

   property p_ovf_wrap;
      @(posedge mclk_in) disable iff (!rst_n)
      (st.count == COUNT_MAX && tick && st.en && !wr_cnt && !in_reset)
         |=> st.ovf && st.count == COUNT_RESET;
   endproperty
   a_ovf_wrap: assert property (p_ovf_wrap) else $error("wrap did not set ovf");

   // the request is registered beside the flag, so it shows in the same cycle as the flag
   property p_interval_irq;
      @(posedge mclk_in) disable iff (!rst_n)
      (overflow && !st.mode && !wr_ctrl) |=> interval_irq_out;
   endproperty
   a_interval_irq: assert property (p_interval_irq) else $error("interval request missing");

   property p_interval_no_reset;
      @(posedge mclk_in) disable iff (!rst_n)
      (overflow && !st.mode) |=> chip_reset_n_out;
   endproperty
   a_interval_no_reset: assert property (p_interval_no_reset) else $error("reset in interval mode");

   property p_trip_kept;
      @(posedge mclk_in) disable iff (!rst_n)
      in_reset |=> st.trip;
   endproperty
   a_trip_kept: assert property (p_trip_kept) else $error("trip flag lost in chip reset");

   property p_count_step;
      @(posedge mclk_in) disable iff (!rst_n)
      (tick && st.en && !wr_cnt && !in_reset) |=> st.count == $past(st.count) + 8'h01;
   endproperty
   a_count_step: assert property (p_count_step) else $error("count did not advance by one");

   property p_write_wins;
      @(posedge mclk_in) disable iff (!rst_n)
      wr_cnt |=> st.count == $past(wdata_in[7:0]);
   endproperty
   a_write_wins: assert property (p_write_wins) else $error("count write lost");

   property p_byte_ignored;
      @(posedge mclk_in) disable iff (!rst_n)
      (wr_in && !wr_word_in && addr_in == ADDR_CTRL && !tick && !in_reset)
         |=> $stable(st.cks) && $stable(st.en)
            && (st.count == ($past(st.en) ? $past(st.count) : COUNT_RESET));
   endproperty
   a_byte_ignored: assert property (p_byte_ignored) else $error("byte write took effect");

   property p_hold_zero;
      @(posedge mclk_in) disable iff (!rst_n)
      (!st.en && !wr_cnt) |=> st.count == COUNT_RESET;
   endproperty
   a_hold_zero: assert property (p_hold_zero) else $error("count not held at zero");

   property p_ovf_clear_needs_read;
      @(posedge mclk_in) disable iff (!rst_n)
      (st.ovf && !st.ovf_armed && !in_reset) |=> st.ovf;
   endproperty
   a_ovf_clear_needs_read: assert property (p_ovf_clear_needs_read)
      else $error("ovf cleared without read");
endmodule : wit_timer

//--- verification/watchdog_interval_timer_bench.sv
// self-checking bench for the watchdog / interval timer top
// assumes the single-cycle strobe register port and active-low outputs of wit_timer
`timescale 1ns/1ps
module watchdog_interval_timer_bench
   import wit_pkg::*;
;
   logic mclk_in;
   logic rst_n_in;
   logic [3:0] addr_in;
   logic [15:0] wdata_in;
   logic wr_in;
   logic wr_word_in;
   logic rd_in;
   logic [7:0] rdata_out;
   logic chip_reset_n_out;
   logic trip_out_pin_n_out;
   logic interval_irq_out;
   logic irq_out;
   int n_errors = 0;
   int n_compared = 0;
   int div_tab [8] = '{2, 32, 64, 128, 256, 512, 2048, 4096};

   wit_timer dut (
      .mclk_in(mclk_in),
      .rst_n_in(rst_n_in),
      .addr_in(addr_in),
      .wdata_in(wdata_in),
      .wr_in(wr_in),
      .wr_word_in(wr_word_in),
      .rd_in(rd_in),
      .rdata_out(rdata_out),
      .chip_reset_n_out(chip_reset_n_out),
      .trip_out_pin_n_out(trip_out_pin_n_out),
      .interval_irq_out(interval_irq_out),
      .irq_out(irq_out)
   );

   initial begin
      mclk_in = 1'b0;
      forever #2 mclk_in = ~mclk_in;
   end

   function automatic logic [7:0] ctrl_exp(input logic ovf, input logic mode, input logic en,
                                           input logic [2:0] cks);
      return {ovf, mode, en, 2'b11, cks};
   endfunction : ctrl_exp

   function automatic logic [7:0] trip_exp(input logic flag, input logic oe);
      return {flag, oe, 6'h3F};
   endfunction : trip_exp

   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : chk

   task automatic do_reset();
      rst_n_in <= 1'b0;
      repeat (20) @(posedge mclk_in);
      rst_n_in <= 1'b1;
      repeat (3) @(posedge mclk_in);
   endtask : do_reset

   task automatic wr(input logic [3:0] a, input logic [15:0] d, input logic word);
      addr_in <= a;
      wdata_in <= d;
      wr_word_in <= word;
      wr_in <= 1'b1;
      @(posedge mclk_in);
      wr_in <= 1'b0;
      @(posedge mclk_in);
   endtask : wr

   // read data stand only in the cycle after the strobe, so sample mid-cycle there
   task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge mclk_in);
      rd_in <= 1'b0;
      @(negedge mclk_in);
      chk({8'h00, rdata_out}, {8'h00, exp});
      @(posedge mclk_in);
   endtask : rd_chk

   task automatic wait_irq(input int limit);
      for (int i = 0; i < limit && interval_irq_out !== 1'b1; i++) @(negedge mclk_in);
      @(negedge mclk_in);
      chk({15'h0000, interval_irq_out}, 16'h0001);
      @(posedge mclk_in);
   endtask : wait_irq

   task automatic look_irq(input logic exp);
      repeat (3) @(posedge mclk_in);
      @(negedge mclk_in);
      chk({14'h0000, irq_out, interval_irq_out}, {14'h0000, exp, exp});
      @(posedge mclk_in);
   endtask : look_irq

   initial begin
      repeat (60000) @(posedge mclk_in);
      n_errors++;
      summarize();
   end

   initial begin
      logic [7:0] v;
      logic [7:0] pw;
      int n_rst;
      int n_pin;
      rst_n_in = 1'b0;
      addr_in = 4'h0;
      wdata_in = 16'h0000;
      wr_in = 1'b0;
      wr_word_in = 1'b0;
      rd_in = 1'b0;
      void'($urandom(32'h224c_6714));
      do_reset();
      rd_chk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 1'b0, 3'h0));
      rd_chk(ADDR_COUNT, 8'h00);
      rd_chk(ADDR_TRIP, trip_exp(1'b0, 1'b0));
      rd_chk(4'hF, 8'h00);
      $display("test reset_values done");
      wr(ADDR_CTRL, {PW_CTRL, 8'h27}, 1'b0);
      rd_chk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 1'b0, 3'h0));
      // slowest divider keeps ticks far away from the short write/read pairs
      wr(ADDR_CTRL, {PW_CTRL, 8'h27}, 1'b1);
      for (int i = 0; i < 4; i++) begin
         v = 8'($urandom);
         pw = 8'($urandom);
         if (pw == PW_COUNT || pw == PW_CTRL) pw = 8'h00;
         wr(ADDR_CTRL, {PW_COUNT, v}, 1'b1);
         rd_chk(ADDR_COUNT, v);
         wr(ADDR_CTRL, {pw, ~v}, 1'b1);
         wr(ADDR_CTRL, {PW_COUNT, ~v}, 1'b0);
         rd_chk(ADDR_COUNT, v);
      end
      $display("test password_writes done");
      for (int c = 0; c < 8; c++) begin
         wr(ADDR_CTRL, {PW_CTRL, 8'h00}, 1'b1);
         rd_chk(ADDR_COUNT, 8'h00);
         wr(ADDR_CTRL, {PW_CTRL, 5'b00100, 3'(c)}, 1'b1);
         repeat (3 * div_tab[c] + div_tab[c] / 2) @(posedge mclk_in);
         rd_chk(ADDR_COUNT, 8'h03);
      end
      $display("test divider_codes done");
      wr(ADDR_CTRL, {PW_CTRL, 8'h00}, 1'b1);
      wr(ADDR_IRQ_EN, 16'h0001, 1'b1);
      rd_chk(ADDR_IRQ_EN, 8'h01);
      wr(ADDR_CTRL, {PW_CTRL, 8'h20}, 1'b1);
      wr(ADDR_CTRL, {PW_COUNT, 8'hF0}, 1'b1);
      wait_irq(100);
      rd_chk(ADDR_IRQ_STAT, 8'h01);
      look_irq(1'b1);
      wr(ADDR_CTRL, {PW_CTRL, 8'h20}, 1'b1);
      rd_chk(ADDR_CTRL, ctrl_exp(1'b1, 1'b0, 1'b1, 3'h0));
      wr(ADDR_CTRL, {PW_CTRL, 8'h20}, 1'b1);
      rd_chk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 1'b1, 3'h0));
      wr(ADDR_IRQ_CLR, 16'h0001, 1'b1);
      rd_chk(ADDR_IRQ_STAT, 8'h00);
      look_irq(1'b0);
      wait_irq(600);
      wr(ADDR_IRQ_EN, 16'h0000, 1'b1);
      repeat (3) @(posedge mclk_in);
      @(negedge mclk_in);
      chk({15'h0000, irq_out}, 16'h0000);
      @(posedge mclk_in);
      wr(ADDR_CTRL, {PW_CTRL, 8'h00}, 1'b1);
      $display("test interval_mode done");
      // kicks well inside the 512-cycle overflow span at the fastest divider
      wr(ADDR_CTRL, {PW_CTRL, 8'h60}, 1'b1);
      for (int k = 0; k < 3; k++) begin
         repeat (300 + 8'($urandom) / 2) @(posedge mclk_in);
         wr(ADDR_CTRL, {PW_COUNT, 8'h00}, 1'b1);
      end
      rd_chk(ADDR_TRIP, trip_exp(1'b0, 1'b0));
      $display("test watchdog_kick done");
      for (int oe = 0; oe < 2; oe++) begin
         wr(ADDR_TRIP, {PW_TRIP_OE, 1'b0, 1'(oe), 6'h00}, 1'b1);
         wr(ADDR_CTRL, {PW_CTRL, 8'h60}, 1'b1);
         wr(ADDR_CTRL, {PW_COUNT, 8'hFF}, 1'b1);
         n_rst = 0;
         n_pin = 0;
         for (int i = 0; i < 700; i++) begin
            @(negedge mclk_in);
            if (chip_reset_n_out === 1'b0) n_rst++;
            if (trip_out_pin_n_out === 1'b0) n_pin++;
         end
         @(posedge mclk_in);
         chk(16'(n_rst), 16'h0206);
         chk(16'(n_pin), (oe == 1) ? 16'h0084 : 16'h0000);
         rd_chk(ADDR_TRIP, trip_exp(1'b1, 1'(oe)));
         rd_chk(ADDR_CTRL, ctrl_exp(1'b0, 1'b0, 1'b0, 3'h0));
         wr(ADDR_TRIP, {PW_TRIP_CLR, TRIP_CLR_DATA}, 1'b1);
         rd_chk(ADDR_TRIP, trip_exp(1'b0, 1'(oe)));
      end
      $display("test watchdog_trip done");
      wr(ADDR_CTRL, {PW_CTRL, 8'h60}, 1'b1);
      wr(ADDR_CTRL, {PW_COUNT, 8'hFF}, 1'b1);
      do_reset();
      @(negedge mclk_in);
      chk({15'h0000, chip_reset_n_out}, 16'h0001);
      @(posedge mclk_in);
      rd_chk(ADDR_TRIP, trip_exp(1'b0, 1'b0));
      $display("test pin_reset_priority done");
      summarize();
   end
endmodule : watchdog_interval_timer_bench
